//--- design/vlstx_pkg.sv
// Purpose: shared constants for the video serial link transmitter
// Assumes: 200 MHz system clock, pixel clock sampled as a plain input
// Notes: counts are in system clock cycles, except LATENCY_PERIODS, which is in pixel clock periods
package vlstx_pkg;
    // word layout
    localparam int GROUPS = 5;
    localparam int BITS = 7;
    localparam int WORD_W = 35;
    // buffering and pipeline depth
    localparam int FIFO_DEPTH = 4;
    localparam int FIFO_LVL_W = 3;
    localparam logic [FIFO_LVL_W-1:0] PRIME_WORDS = 3'h2;
    localparam int LATENCY_PERIODS = 3;
    // slot timing
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;
    localparam logic [CNT_W-1:0] BIT_STEP = 8'h07;
    localparam logic [2:0] LAST_SLOT = 3'h6;
    localparam logic [2:0] FWD_HIGH_SLOTS = 3'h4;
    // clock figures
    localparam int CLK_PERIOD_PS = 5000;
    localparam int PIX_PERIOD_MAX_PS = 125000;
    localparam int PIX_PERIOD_MAX_CYC = PIX_PERIOD_MAX_PS / CLK_PERIOD_PS;
    // reset values
    localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;
    localparam logic [2:0] SLOT_RESET = 3'h0;
endpackage : vlstx_pkg

//--- design/vlstx_fifo.sv
// Purpose: small word buffer between capture and serializer
// Assumes: DEPTH is a power of two
// Notes: flush empties it in one cycle
`timescale 1ns/1ps
module vlstx_fifo #(
    parameter int WIDTH = 35,
    parameter int DEPTH = 4
) (
    input wire logic clk, // system clock
    input wire logic rst_n, // sync reset, active low
    input wire logic clk_en, // freezes state when low
    input wire logic flush, // drop all words
    input wire logic in_valid, // word offered
    output logic in_ready, // room for a word
    input wire logic [WIDTH-1:0] in_data, // word in
    output logic out_valid, // word available
    input wire logic out_ready, // word taken
    output logic [WIDTH-1:0] out_data, // oldest word
    output logic [$clog2(DEPTH+1)-1:0] level // words held
);
    localparam int PW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH+1);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [LW-1:0] cnt_q, cnt_d;
    logic push, pop;

    // honest flags from the count
    assign in_ready = (cnt_q != LW'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    assign level = cnt_q;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // next pointers, count and storage
    always_comb begin
        mem_d = mem_q;
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        if (flush) begin
            wr_d = '0;
            rd_d = '0;
            cnt_d = '0;
        end else begin
            if (push) begin
                mem_d[wr_q] = in_data;
                wr_d = wr_q + PW'(1);
            end
            if (pop) begin
                rd_d = rd_q + PW'(1);
            end
            cnt_d = cnt_q + LW'(push) - LW'(pop);
        end
    end

    // register stage
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else if (clk_en) begin
            mem_q <= mem_d;
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end
endmodule : vlstx_fifo

//--- design/vlstx_top.sv
// Purpose: 35-bit parallel to five 7:1 serial pairs plus forwarded clock
// Assumes: pixel clock and data sampled by clk; slots approximated in clk cycles
// Notes: power-down holds logic cleared and drops all output enables
// Notes on behaviour
// - every active pixel clock edge takes one 35-bit word for serial transmission
// - word splits into five groups of seven, each driving one pair
// - a forwarded clock pair runs alongside the data pairs
// - each pair carries seven bit slots per pixel clock period
// - edge select high samples on rising edge, low on falling edge
// - power-down low stops operation and releases all outputs
// - data lags the input by about three periods; forwarded clock restarts within about four clk cycles of each active edge
// - slot timing is derived from the measured, possibly spreading, input period
`timescale 1ns/1ps
module vlstx_top
    import vlstx_pkg::*;
(
    input wire logic clk, // system clock, 200 MHz
    input wire logic rst_n, // sync reset, active low
    input wire logic clk_en, // freezes all state when low
    input wire logic pixel_clock_in, // pixel clock pin
    input wire logic edge_select, // 1 rising, 0 falling
    input wire logic power_down_n, // power-down, active low
    input wire logic [6:0] group_a_parallel_in, // group a bits
    input wire logic [6:0] group_b_parallel_in, // group b bits
    input wire logic [6:0] group_c_parallel_in, // group c bits
    input wire logic [6:0] group_d_parallel_in, // group d bits
    input wire logic [6:0] group_e_parallel_in, // group e bits
    output logic serial_pair_a_p, // pair a true
    output logic serial_pair_a_n, // pair a complement
    output logic serial_pair_b_p, // pair b true
    output logic serial_pair_b_n, // pair b complement
    output logic serial_pair_c_p, // pair c true
    output logic serial_pair_c_n, // pair c complement
    output logic serial_pair_d_p, // pair d true
    output logic serial_pair_d_n, // pair d complement
    output logic serial_pair_e_p, // pair e true
    output logic serial_pair_e_n, // pair e complement
    output logic forwarded_clock_pair_p, // clock true
    output logic forwarded_clock_pair_n, // clock complement
    output logic pair_oe, // all pairs driven
    output logic in_ready // buffer has room
);
    logic [2:0] pclk_s;
    logic [1:0] edge_s, power_down_n_s;
    logic [WORD_W-1:0] data_s1, data_s2, data_s3;
    logic pd_w, rise_w, fall_w, active_w, pop_w, push_w;
    logic fifo_in_ready, fifo_out_valid;
    logic [WORD_W-1:0] fifo_out_data;
    logic [FIFO_LVL_W-1:0] fifo_level;
    logic [CNT_W-1:0] cnt_q, cnt_d, period_q, period_d, acc_q, acc_d;
    logic [CNT_W:0] acc_sum;
    logic [2:0] slot_q, slot_d, bit_idx;
    logic primed_q, primed_d;
    logic [WORD_W-1:0] word_q, word_d;
    logic [GROUPS-1:0] ser_p_q, ser_p_d, ser_n_q, ser_n_d;
    logic fwd_p_q, fwd_p_d, fwd_n_q, fwd_n_d, oe_q, oe_d, rdy_q, rdy_d;

    // slot to bit index within a group
    function automatic logic [2:0] slot_bit(input logic [2:0] s);
        logic [2:0] r;
        r = 3'h0;
        if (s == 3'h0) begin
            r = 3'h1;
        end else if (s == 3'h1) begin
            r = 3'h0;
        end else begin
            r = 3'(4'h8 - {1'b0, s});
        end
        return r;
    endfunction : slot_bit

    // pin synchronisers; data one stage deeper so it predates the edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pclk_s <= 3'h0;
            edge_s <= 2'h0;
            power_down_n_s <= 2'h0;
            data_s1 <= '0;
            data_s2 <= '0;
            data_s3 <= '0;
        end else if (clk_en) begin
            pclk_s <= {pclk_s[1:0], pixel_clock_in};
            edge_s <= {edge_s[0], edge_select};
            power_down_n_s <= {power_down_n_s[0], power_down_n};
            data_s1 <= {group_e_parallel_in, group_d_parallel_in, group_c_parallel_in,
                        group_b_parallel_in, group_a_parallel_in};
            data_s2 <= data_s1;
            data_s3 <= data_s2;
        end
    end

    // edge detection and buffer handshakes
    assign pd_w = !power_down_n_s[1];
    assign rise_w = pclk_s[1] && !pclk_s[2];
    assign fall_w = !pclk_s[1] && pclk_s[2];
    assign active_w = edge_s[1] ? rise_w : fall_w;
    assign push_w = active_w && !pd_w && fifo_in_ready;
    assign pop_w = active_w && primed_q && !pd_w && fifo_out_valid;

    vlstx_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .flush(pd_w),
        .in_valid(active_w && !pd_w),
        .in_ready(fifo_in_ready),
        .in_data(data_s3),
        .out_valid(fifo_out_valid),
        .out_ready(pop_w),
        .out_data(fifo_out_data),
        .level(fifo_level)
    );

    assign acc_sum = {1'b0, acc_q} + {1'b0, BIT_STEP};
    assign bit_idx = slot_bit(slot_q);

    // period measure, slot generator, serializer next values
    always_comb begin
        cnt_d = (cnt_q == CNT_MAX) ? cnt_q : cnt_q + 8'h01;
        period_d = period_q;
        acc_d = acc_q;
        slot_d = slot_q;
        primed_d = primed_q;
        word_d = word_q;
        // seven equal slots per measured period
        if (period_q == CNT_RESET) begin
            acc_d = CNT_RESET;
        end else if (acc_sum >= {1'b0, period_q}) begin
            acc_d = CNT_W'(acc_sum - {1'b0, period_q});
            if (slot_q != LAST_SLOT) begin
                slot_d = slot_q + 3'h1;
            end
        end else begin
            acc_d = acc_sum[CNT_W-1:0];
        end
        if (active_w) begin
            period_d = (cnt_q == CNT_MAX) ? cnt_q : cnt_q + 8'h01;
            cnt_d = CNT_RESET;
            acc_d = CNT_RESET;
            slot_d = SLOT_RESET;
            if (fifo_level >= PRIME_WORDS) begin
                primed_d = 1'b1;
            end
        end
        if (pop_w) begin
            word_d = fifo_out_data;
        end
        // one bit of each group per slot
        for (int g = 0; g < GROUPS; g++) begin
            ser_p_d[g] = word_q[g*BITS + int'(bit_idx)];
            ser_n_d[g] = !word_q[g*BITS + int'(bit_idx)];
        end
        fwd_p_d = (slot_q < FWD_HIGH_SLOTS);
        fwd_n_d = !(slot_q < FWD_HIGH_SLOTS);
        oe_d = !pd_w;
        rdy_d = fifo_in_ready && !pd_w;
        // power-down clears everything and releases the pins
        if (pd_w) begin
            cnt_d = CNT_RESET;
            period_d = CNT_RESET;
            acc_d = CNT_RESET;
            slot_d = SLOT_RESET;
            primed_d = 1'b0;
            word_d = '0;
            ser_p_d = '0;
            ser_n_d = '0;
            fwd_p_d = 1'b0;
            fwd_n_d = 1'b0;
        end
    end

    // register stage
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= CNT_RESET;
            period_q <= CNT_RESET;
            acc_q <= CNT_RESET;
            slot_q <= SLOT_RESET;
            primed_q <= 1'b0;
            word_q <= '0;
            ser_p_q <= '0;
            ser_n_q <= '0;
            fwd_p_q <= 1'b0;
            fwd_n_q <= 1'b0;
            oe_q <= 1'b0;
            rdy_q <= 1'b0;
        end else if (clk_en) begin
            cnt_q <= cnt_d;
            period_q <= period_d;
            acc_q <= acc_d;
            slot_q <= slot_d;
            primed_q <= primed_d;
            word_q <= word_d;
            ser_p_q <= ser_p_d;
            ser_n_q <= ser_n_d;
            fwd_p_q <= fwd_p_d;
            fwd_n_q <= fwd_n_d;
            oe_q <= oe_d;
            rdy_q <= rdy_d;
        end
    end

    // outputs straight from flops
    assign {serial_pair_e_p, serial_pair_d_p, serial_pair_c_p, serial_pair_b_p,
            serial_pair_a_p} = ser_p_q;
    assign {serial_pair_e_n, serial_pair_d_n, serial_pair_c_n, serial_pair_b_n,
            serial_pair_a_n} = ser_n_q;
    assign forwarded_clock_pair_p = fwd_p_q;
    assign forwarded_clock_pair_n = fwd_n_q;
    assign pair_oe = oe_q;
    assign in_ready = rdy_q;

    // checks on the serializer
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n || !clk_en);

    a_pd_outputs_off: assert property (pd_w |=> !oe_q && ser_p_q == '0 && !fwd_p_q)
        else $error("outputs not released in power-down");
    a_pair_complement: assert property (oe_q |-> ser_p_q == ~ser_n_q)
        else $error("data pair legs not complementary");
    a_fwd_clock_high: assert property (!pd_w && slot_q < FWD_HIGH_SLOTS |=> fwd_p_q && !fwd_n_q)
        else $error("forwarded clock not high in early slots");
    a_rise_edge_push: assert property (rise_w && edge_s[1] && !pd_w && fifo_in_ready |-> push_w)
        else $error("rising edge not captured");
    a_fall_edge_push: assert property (fall_w && !edge_s[1] && !pd_w && fifo_in_ready |-> push_w)
        else $error("falling edge not captured");
    a_word_load: assert property (pop_w && !pd_w |=> word_q == $past(fifo_out_data))
        else $error("popped word not loaded");
    a_slot_restart: assert property (active_w && !pd_w |=> slot_q == 3'h0 ##1 slot_q <= LAST_SLOT)
        else $error("slot counter not restarted on edge");
    a_acc_bound: assert property (period_q > BIT_STEP |-> acc_q < period_q)
        else $error("slot accumulator out of range");
    a_bit_order: assert property (oe_q && !pd_w && slot_q == 3'h1 && !active_w |=> ser_p_q[0] == word_q[0])
        else $error("slot one does not carry bit zero");
    a_pop_primed: assert property (pop_w |-> primed_q && fifo_level >= 3'h1)
        else $error("word sent before pipeline primed");
endmodule : vlstx_top

//--- tb/vlstx_rx_model.sv
// Purpose: receiver model recovering words from the serial pairs
// Assumes: pairs sampled on clk, slot centres taken from the measured period
// Notes: flags one word for each finished forwarded clock period
`timescale 1ns/1ps
module vlstx_rx_model
    import vlstx_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic oe, // pairs driven
    input wire logic fwd_p, // forwarded clock true side
    input wire logic [GROUPS-1:0] dat_p, // pairs a..e true side
    output logic rx_valid, // word ready, one cycle
    output logic [WORD_W-1:0] rx_word // recovered word
);
    localparam int ORD [BITS] = '{1, 0, 6, 5, 4, 3, 2};
    logic [GROUPS-1:0] smp [64];
    logic have = 1'b0;
    logic prev = 1'b0;
    int cnt = 0;
    initial rx_valid = 1'b0;
    // a clock rise closes the period: read each slot at its centre
    always @(posedge clk) begin
        rx_valid <= 1'b0;
        if (oe !== 1'b1) begin
            have <= 1'b0;
        end else if (fwd_p && !prev) begin
            if (have) begin
                for (int s = 0; s < BITS; s++) begin
                    for (int g = 0; g < GROUPS; g++) begin
                        rx_word[g*BITS+ORD[s]] <= smp[((2*s+1)*cnt+7)/14][g];
                    end
                end
                rx_valid <= 1'b1;
            end
            have <= 1'b1;
            cnt = 0;
        end
        smp[cnt] = dat_p;
        if (cnt < 63) cnt++; // long gaps saturate
        prev <= fwd_p;
    end
endmodule : vlstx_rx_model

//--- tb/video_lvds_serializer_tx_test.sv
// Purpose: self-checking bench for the serial video link transmitter
// Assumes: 200 MHz clk, 125 ns pixel clock, receiver model on the pairs
// Notes: buffer watched through the top; wake-ups follow an inactive pixel edge
`timescale 1ns/1ps
module video_lvds_serializer_tx_test
    import vlstx_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic pix = 1'b0;
    logic esel = 1'b1;
    logic pdn = 1'b0; // held in power-down until the first wake
    logic [WORD_W-1:0] drv = '0;
    logic [WORD_W-1:0] rxw;
    logic [GROUPS-1:0] sp, sn;
    logic fp, fn, oe, rdy, rxv;
    logic [WORD_W-1:0] q [$];
    int err_count = 0;
    int comparisons = 0;
    int widx = 0;
    always #2.5 clk = ~clk;
    vlstx_top u_vlstx_top (
        .clk(clk), .rst_n(rst_n), .clk_en(1'b1), .pixel_clock_in(pix),
        .edge_select(esel), .power_down_n(pdn),
        .group_a_parallel_in(drv[6:0]), .group_b_parallel_in(drv[13:7]),
        .group_c_parallel_in(drv[20:14]), .group_d_parallel_in(drv[27:21]),
        .group_e_parallel_in(drv[34:28]),
        .serial_pair_a_p(sp[0]), .serial_pair_a_n(sn[0]),
        .serial_pair_b_p(sp[1]), .serial_pair_b_n(sn[1]),
        .serial_pair_c_p(sp[2]), .serial_pair_c_n(sn[2]),
        .serial_pair_d_p(sp[3]), .serial_pair_d_n(sn[3]),
        .serial_pair_e_p(sp[4]), .serial_pair_e_n(sn[4]),
        .forwarded_clock_pair_p(fp), .forwarded_clock_pair_n(fn),
        .pair_oe(oe), .in_ready(rdy));
    vlstx_rx_model u_vlstx_rx_model (
        .clk(clk), .oe(oe), .fwd_p(fp), .dat_p(sp), .rx_valid(rxv), .rx_word(rxw));
    task automatic chk_word(string name, logic [WORD_W-1:0] exp, logic [WORD_W-1:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_word
    task automatic chk_bit(string name, logic exp, logic got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %s expected %b seen %b", name, exp, got);
        end
    endtask : chk_bit
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test
    // corner words first, then random colour and control fields
    function automatic logic [WORD_W-1:0] next_word(int n);
        case (n)
            0: return '0;
            1: return '1;
            2: return {7{5'h15}};
            default: return {5'($urandom), 30'($urandom)};
        endcase
    endfunction : next_word
    // words held after the n-th captured word: pops start once primed
    function automatic int fill_exp(int n);
        return (n > int'(PRIME_WORDS)) ? int'(PRIME_WORDS) + 1 : n;
    endfunction : fill_exp
    // pixel clock; data only valid across the active edge, junk across the other
    initial begin
        forever begin
            repeat (pix ? 13 : 12) @(negedge clk);
            pix = ~pix;
            if (pix == esel) begin
                if (pdn) q.push_back(drv);
                drv = WORD_W'({$urandom, $urandom});
            end else begin
                drv = next_word(widx);
                widx++;
            end
        end
    end
    // score words once the pipe is full: three periods to the pins, one more to decode;
    // earlier frames after a wake carry no captured word
    always @(negedge clk) begin
        if (rxv === 1'b1 && pdn && q.size() > LATENCY_PERIODS + 1) begin
            chk_word("recovered word", q.pop_front(), rxw);
            chk_word("words in flight", LATENCY_PERIODS + 1, q.size());
            chk_word("pair complements", {29'h0, ~sp, ~fp}, {29'h0, sn, fn});
        end
    end
    // leave power-down just after an inactive pixel edge, so bench and block
    // agree on the first word taken; that word is the first corner word
    task automatic wake(logic es);
        esel = es;
        widx = 0;
        wait (pix == es);
        wait (pix != es);
        pdn = 1'b1;
    endtask : wake
    task automatic run_phase(logic es, int periods);
        @(negedge clk);
        pdn = 1'b0;
        q.delete();
        repeat (6) @(negedge clk);
        chk_word("pins in power-down", '0, {sp, sn, fp, fn, oe, rdy});
        chk_word("fifo level in power-down", '0, u_vlstx_top.fifo_level);
        wake(es);
        repeat (3) @(negedge clk);
        chk_bit("enable after wake", 1'b1, oe);
        repeat (periods * 25) @(negedge clk);
        chk_bit("ready while streaming", 1'b1, rdy);
        $display("stream test, edge select %0b, done", es);
    endtask : run_phase
    // buffer seen through the top: fills to one word past the priming depth, then holds steady
    task automatic fifo_test;
        chk_word("fifo level flushed", '0, u_vlstx_top.fifo_level);
        chk_bit("fifo empty", 1'b0, u_vlstx_top.fifo_out_valid);
        wake(esel);
        for (int i = 1; i <= 5; i++) begin
            wait (pix != esel);
            wait (pix == esel);
            repeat (6) @(negedge clk);
            chk_word("fifo fill level", fill_exp(i), u_vlstx_top.fifo_level);
        end
        chk_bit("fifo holds words", 1'b1, u_vlstx_top.fifo_out_valid);
        chk_bit("fifo accepts", 1'b1, u_vlstx_top.fifo_in_ready);
        chk_word("fifo order", q[0], u_vlstx_top.word_q);
        $display("fifo test done");
    endtask : fifo_test
    initial begin
        void'($urandom(65));
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        chk_word("outputs after reset", '0, {sp, sn, fp, fn, oe});
        fifo_test();
        run_phase(1'b1, 40);
        run_phase(1'b0, 40);
        run_phase(1'b1, 20);
        end_of_test();
    end
    // watchdog well beyond the expected run of about 2700 cycles
    initial begin
        repeat (8000) @(posedge clk);
        err_count++;
        $display("FAIL watchdog expected finish seen timeout");
        end_of_test();
    end
endmodule : video_lvds_serializer_tx_test
